// ### hw/nvsc_host.v
// Host-side controller driving the battery-backed static memory pins
// Functional notes
// - Host holds address unchanged through the whole write cycle.
// - Host keeps write enable high for recovery time before next access.
// - Host keeps output enable high during writes to avoid contention.
// - No accesses until supply has been good for the supply-good wait time.
`include "nvsc_map.vh"
module nvsc_host #(
  parameter SUPPLY_GOOD_WAIT_CYC = `NVSC_SUPPLY_GOOD_WAIT_CYC
) (
  input wire i_clock, // 10 MHz system clock
  input wire i_arst_n, // Async reset, active low
  input wire i_req, // Access request pulse
  input wire i_req_write, // 1 write, 0 read
  input wire [`NVSC_ADDR_W-1:0] i_req_addr, // Access address
  input wire [`NVSC_DATA_W-1:0] i_req_wdata, // Write data
  output reg o_busy, // Busy or not yet ready
  output reg o_ready, // Memory usable (power good and waited)
  output reg o_done, // One-cycle completion pulse
  output reg [`NVSC_DATA_W-1:0] o_rdata, // Read data, valid with o_done
  output reg o_refused, // One-cycle pulse: request dropped
  output reg [`NVSC_ADDR_W-1:0] o_address_lines, // Memory address pins
  output reg o_chip_sel_n, // Memory chip select, active low
  output reg o_write_en_n, // Memory write enable, active low
  output reg o_out_en_n, // Memory output enable, active low
  output reg [`NVSC_DATA_W-1:0] o_data_lines_o, // Data pins, driven value
  output reg o_data_lines_oe, // Data pins, high while host drives
  input wire [`NVSC_DATA_W-1:0] i_data_lines_i, // Data pins, sampled value
  input wire i_pfail_rst_n // Memory power-fail reset pin (open drain, pulled up)
);
  localparam ST_WAIT = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_READ = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_RECOVER = 3'h4;
  localparam [7:0] ACC_CYC = `NVSC_ACCESS_CYC;
  localparam [7:0] WR_CYC = `NVSC_WRITE_CYC;
  localparam [7:0] REC_CYC = `NVSC_RECOVERY_CYC;
  localparam [`NVSC_CNT_W-1:0] GOOD_CYC = SUPPLY_GOOD_WAIT_CYC[`NVSC_CNT_W-1:0];

  wire [`NVSC_DATA_W:0] sync_out;
  wire [`NVSC_DATA_W-1:0] rdata_sync;
  wire pgood_sync;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg [`NVSC_CNT_W-1:0] good_cnt_reg;
  reg write_op_reg;
  wire access_start;
  wire access_end;

  // Pins from the memory are asynchronous; resynchronise data and reset
  nvsc_sync #(.W(`NVSC_DATA_W + 1)) u_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async({i_pfail_rst_n, i_data_lines_i}),
    .o_sync(sync_out)
  );
  assign rdata_sync = sync_out[`NVSC_DATA_W-1:0];
  assign pgood_sync = sync_out[`NVSC_DATA_W];

  // Supply-good timer restarts whenever the memory reports power fail
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      good_cnt_reg <= {`NVSC_CNT_W{1'b0}};
    else if (!pgood_sync)
      good_cnt_reg <= {`NVSC_CNT_W{1'b0}};
    else if (good_cnt_reg != GOOD_CYC)
      good_cnt_reg <= good_cnt_reg + 1'b1;
  end

  // Access sequencer; synchroniser delay covers data settle after the wait
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_WAIT:
      begin
        if (pgood_sync && good_cnt_reg == GOOD_CYC)
          state_next = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (!pgood_sync)
          state_next = ST_WAIT;
        else if (i_req)
        begin
          cnt_next = i_req_write ? WR_CYC : ACC_CYC + 8'h02;
          state_next = i_req_write ? ST_WRITE : ST_READ;
        end
      end
      ST_READ, ST_WRITE:
      begin
        if (cnt_reg > 8'h01)
          cnt_next = cnt_reg - 8'h01;
        else
        begin
          cnt_next = REC_CYC;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        if (cnt_reg > 8'h01)
          cnt_next = cnt_reg - 8'h01;
        else
          state_next = pgood_sync ? ST_IDLE : ST_WAIT;
      end
      default:
        state_next = ST_WAIT;
    endcase
  end

  // Access boundaries, shared by the pin registers and the done and read data registers
  assign access_start = (state_reg == ST_IDLE) && (state_next == ST_READ || state_next == ST_WRITE);
  assign access_end = (state_reg == ST_READ || state_reg == ST_WRITE) && state_next == ST_RECOVER;

  // State and counter registers
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg <= ST_WAIT;
      cnt_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Busy and ready follow the next state, so busy rises on the edge the strobes fall; refused follows the current state
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_busy <= 1'b1;
      o_ready <= 1'b0;
      o_refused <= 1'b0;
    end
    else
    begin
      o_refused <= i_req && (state_reg != ST_IDLE || !pgood_sync);
      o_ready <= (state_next != ST_WAIT);
      o_busy <= (state_next != ST_IDLE);
    end
  end

  // Completion pulse; read data move only on a finished read and then stand
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_done <= 1'b0;
      o_rdata <= {`NVSC_DATA_W{1'b0}};
    end
    else
    begin
      o_done <= access_end;
      if (access_end && !write_op_reg)
        o_rdata <= rdata_sync;
    end
  end

  // Address and write data launch with the strobes and stay put until the next access
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      write_op_reg <= 1'b0;
      o_address_lines <= {`NVSC_ADDR_W{1'b0}};
      o_data_lines_o <= {`NVSC_DATA_W{1'b0}};
    end
    else if (access_start)
    begin
      write_op_reg <= i_req_write;
      o_address_lines <= i_req_addr;
      o_data_lines_o <= i_req_wdata;
    end
  end

  // Select and the write or output enable go down together at the start of an access
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_chip_sel_n <= 1'b1;
      o_write_en_n <= 1'b1;
      o_out_en_n <= 1'b1;
      o_data_lines_oe <= 1'b0;
    end
    else if (access_start)
    begin
      o_chip_sel_n <= 1'b0;
      o_write_en_n <= !i_req_write;
      o_out_en_n <= i_req_write;
      o_data_lines_oe <= i_req_write;
    end
    else if (access_end)
    begin
      // Both strobes rise together; data held one more cycle for hold time
      o_chip_sel_n <= 1'b1;
      o_write_en_n <= 1'b1;
      o_out_en_n <= 1'b1;
    end
    else if (state_reg == ST_RECOVER)
      o_data_lines_oe <= 1'b0;
    else if (state_reg == ST_WAIT)
    begin
      // Hold the memory idle while power is unsure; it ignores pins anyway
      o_chip_sel_n <= 1'b1;
      o_write_en_n <= 1'b1;
      o_out_en_n <= 1'b1;
      o_data_lines_oe <= 1'b0;
    end
  end
endmodule // nvsc_host

// ### hw/nvsc_map.vh
// Constants for the host-side controller of the battery-backed static memory
`ifndef NVSC_MAP_VH
`define NVSC_MAP_VH
`define NVSC_ADDR_W 17
`define NVSC_DATA_W 8
`define NVSC_CLK_PERIOD_NS 100
// Access timing in ns (speed grade assumption, slowest variant)
`define NVSC_ACCESS_TIME_NS 100
`define NVSC_WRITE_PULSE_NS 75
`define NVSC_WRITE_RECOVERY_NS 5
`define NVSC_SETUP_NS 0
// Least times in whole 100 ns cycles, rounded up, never under one; sized to fit the 8-bit counter
`define NVSC_ACCESS_CYC 8'h01
`define NVSC_WRITE_CYC 8'h01
`define NVSC_RECOVERY_CYC 8'h01
// Supply-good wait before first access, in ms
`define NVSC_SUPPLY_GOOD_WAIT_MS 200
`define NVSC_SUPPLY_GOOD_WAIT_CYC (`NVSC_SUPPLY_GOOD_WAIT_MS * 10000)
`define NVSC_CNT_W 24
`endif

// ### hw/nvsc_sync.v
// Two-flop synchroniser for asynchronous pin inputs, one per bit
module nvsc_sync #(
  parameter W = 1
) (
  input wire i_clock, // System clock
  input wire i_arst_n, // Async reset, active low
  input wire [W-1:0] i_async, // Unsynchronised input
  output wire [W-1:0] o_sync // Synchronised output
);
  genvar g;
  // Each bit gets its own two stages; only the second stage is read
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge i_clock or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate
endmodule // nvsc_sync

// ### bench/nvsc_host_sva.sv
// Pin-timing checker bound to the host controller
module nvsc_host_sva (
  input wire i_clock, // Clock
  input wire i_arst_n, // Reset
  input wire i_req, // Request
  input wire i_pfail_rst_n, // Power fail
  input wire o_busy, // Busy
  input wire o_ready, // Ready
  input wire o_done, // Done
  input wire o_refused, // Refused
  input wire o_chip_sel_n, // Select
  input wire o_write_en_n, // Write
  input wire o_out_en_n, // Output enable
  input wire o_data_lines_oe // Data drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // Strobes rise together with done
  sequence wr_close;
    $rose(o_write_en_n) && $rose(o_chip_sel_n) && o_done;
  endsequence
  // Read holds three cycles to cover the synchroniser
  sequence rd_hold;
    !o_out_en_n [*3] ##1 (o_out_en_n && o_done);
  endsequence
  wr_pulse_a: assert property ($fell(o_write_en_n) |-> !o_chip_sel_n ##1 wr_close) else $error("wr");
  rd_hold_a: assert property ($fell(o_out_en_n) |-> rd_hold) else $error("rd");
  wr_drive_a: assert property (!o_write_en_n |-> !o_chip_sel_n && o_out_en_n && o_data_lines_oe)
    else $error("wr pins");
  rd_bus_a: assert property (!o_out_en_n |-> !o_chip_sel_n && !o_data_lines_oe) else $error("rd pins");
  standby_a: assert property (o_chip_sel_n |-> o_write_en_n && o_out_en_n) else $error("standby");
  start_ok_a: assert property ($fell(o_chip_sel_n) |-> o_ready) else $error("early");
  refuse_a: assert property (i_req && o_busy |=> o_refused) else $error("refuse");
  pfail_a: assert property (!i_pfail_rst_n |-> ##[1:8] !o_ready) else $error("pfail");
endmodule // nvsc_host_sva
bind nvsc_host nvsc_host_sva u_nvsc_host_sva (.*);

// ### bench/nvsc_mem_model.sv
// Behavioural model of the battery-backed byte-wide static memory
module nvsc_mem_model #(
  parameter HOLD_NS = 500 // Power-up reset timeout, shortened
) (
  input wire logic [16:0] i_address_lines, // Address
  input wire logic i_chip_sel_n, // Select
  input wire logic i_write_en_n, // Write enable
  input wire logic i_out_en_n, // Output enable
  input wire logic [7:0] i_data_lines, // Data bus
  input wire logic i_supply_ok, // Supply in tolerance
  output logic [7:0] o_data_q, // Read data
  output wire logic o_drive, // Drives data bus
  output wire logic o_pfail_rst_n // Power-fail reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_reg [0:131071];
  logic wr_on = 1'b0;
  logic [16:0] wr_addr;
  logic [7:0] wr_data;
  // Drive after access delay; write enable low or supply bad turns it off
  assign #40 o_drive = i_supply_ok && !i_chip_sel_n && i_write_en_n && !i_out_en_n;
  // Falls at once, rises only after the timeout
  assign #(HOLD_NS, 0) o_pfail_rst_n = i_supply_ok;
  always @(o_drive or i_address_lines)
    if (o_drive)
      o_data_q = mem_reg[i_address_lines];
  // Tracks data while both strobes low, stores on first rise
  always @*
    if (i_supply_ok && !i_chip_sel_n && !i_write_en_n)
    begin
      wr_on = 1'b1;
      wr_addr = i_address_lines;
      wr_data = i_data_lines;
    end
    else if (wr_on && i_supply_ok)
    begin
      mem_reg[wr_addr] = wr_data;
      wr_on = 1'b0;
    end
endmodule // nvsc_mem_model

// ### bench/tb_top.sv
// Self-checking bench for the static memory host controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_req = 1'b0;
  logic i_req_write = 1'b0;
  logic [16:0] i_req_addr = 17'h00000;
  logic [7:0] i_req_wdata = 8'h00;
  logic supply_ok = 1'b1;
  logic refused_seen = 1'b0;
  logic [7:0] done_count = 8'h00;
  wire o_busy, o_ready, o_done, o_refused, o_chip_sel_n, o_write_en_n, o_out_en_n, o_data_lines_oe;
  wire mem_drive, i_pfail_rst_n;
  wire [16:0] o_address_lines;
  wire [7:0] o_rdata, o_data_lines_o, mem_q, i_data_lines_i;
  int fail_count = 0;
  int total_checks = 0;
  // Undriven bus shows the inverse of the memory's last output value
  assign i_data_lines_i = o_data_lines_oe ? o_data_lines_o : mem_drive ? mem_q : ~mem_q;
  always #50 i_clock = ~i_clock;
  nvsc_host #(.SUPPLY_GOOD_WAIT_CYC(20)) u_nvsc_host (.*);
  nvsc_mem_model u_nvsc_mem_model (.i_address_lines(o_address_lines), .i_chip_sel_n(o_chip_sel_n),
    .i_write_en_n(o_write_en_n), .i_out_en_n(o_out_en_n), .i_data_lines(i_data_lines_i),
    .i_supply_ok(supply_ok), .o_data_q(mem_q), .o_drive(mem_drive), .o_pfail_rst_n(i_pfail_rst_n));
  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for ready and idle, noting refusals on the way
  task automatic wait_idle();
    for (int n = 0; !(o_ready === 1'b1 && o_busy === 1'b0); n++)
    begin
      if (o_refused === 1'b1)
        refused_seen = 1'b1;
      if (o_done === 1'b1)
        done_count++;
      if (n == 100)
      begin
        chk(8'h00, 8'h01);
        wrap_up();
      end
      @(posedge i_clock);
      #1;
    end
  endtask
  // Request held for the given number of edges
  task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d, input int hold);
    refused_seen = 1'b0;
    done_count = 8'h00;
    @(posedge i_clock);
    i_req <= 1'b1;
    i_req_write <= wr;
    i_req_addr <= a;
    i_req_wdata <= d;
    repeat (hold) @(posedge i_clock);
    i_req <= 1'b0;
    // Let the design's registers settle before polling busy
    #1;
    wait_idle();
  endtask
  task automatic sc_rw();
    access(1'b1, 17'h00000, 8'h5A, 1);
    access(1'b1, 17'h1FFFF, 8'hA5, 1);
    access(1'b0, 17'h00000, 8'h00, 1);
    chk(o_rdata, 8'h5A);
    access(1'b0, 17'h1FFFF, 8'h00, 1);
    chk(o_rdata, 8'hA5);
  endtask
  // Second request while busy must be dropped, first one kept
  task automatic sc_refuse();
    access(1'b1, 17'h00001, 8'hC3, 2);
    chk({7'h00, refused_seen}, 8'h01);
    chk(done_count, 8'h01);
    access(1'b0, 17'h00001, 8'h00, 1);
    chk(o_rdata, 8'hC3);
  endtask
  // Supply loss: not ready, early request dropped, contents kept
  task automatic sc_power();
    supply_ok = 1'b0;
    repeat (8) @(posedge i_clock);
    #1;
    chk({7'h00, o_ready}, 8'h00);
    supply_ok = 1'b1;
    access(1'b0, 17'h1FFFF, 8'h00, 1);
    chk({7'h00, refused_seen}, 8'h01);
    chk(done_count, 8'h00);
    access(1'b0, 17'h1FFFF, 8'h00, 1);
    chk(o_rdata, 8'hA5);
  endtask
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_arst_n <= 1'b1;
    #1;
    chk({7'h00, o_ready}, 8'h00);
    wait_idle();
    sc_rw();
    sc_refuse();
    sc_power();
    wrap_up();
  end
endmodule // tb_top
